// file: hdl/mic_regs.sv
// MAC interface control and status registers with Wishbone access
// Functional notes
// - Line loopback bit loops media receive to transmit; cleared on both resets.
// - Link-down MAC speed from bits 6 (high) and 13 (low).
// - Speed and timing writes take effect only after a software reset.
// - Receive timing bit resets to one; one centres clock on stable data.
// - Transmit timing bit resets to one; one delays incoming transmit clock.
// - Carrier extension block bit: zero on hardware reset, kept on soft reset.
// - Supply level bit initial value: config codes 10, 01 give one.
// - Read-only status bit reads one when 1.8V I/O supply in use.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
module mic_regs #(
  parameter int REG_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [1:0] config_i,
  input wire logic low_io_supply_i,
  input wire logic link_up_i,
  input wire logic mac_loopback_i,
  input wire logic [1:0] link_speed_i,
  output mic_pkg::mic_ctrl_t ctrl_o,
  output logic [1:0] mac_speed_o,
  output logic soft_reset_o
);
  localparam int IM_LOW_NIB_W = $bits(mic_pkg::IM_RSV_3_0_RST);
  logic wr;
  logic rd;
  logic [REG_W-1:0] wdat;
  logic [1:0] lanes;

  // Written (pending) values and active values
  logic loop_q, loop_d;
  logic [1:0] spd_pend_q, spd_pend_d, spd_act_q, spd_act_d;
  logic rxt_pend_q, rxt_pend_d, rxt_act_q, rxt_act_d;
  logic txt_pend_q, txt_pend_d, txt_act_q, txt_act_d;
  logic bce_q, bce_d;
  logic sup_q, sup_d;
  logic b15_q, b15_d;
  logic b7_q, b7_d;
  logic b6_q, b6_d;
  logic [3:0] r11_8_q, r11_8_d;
  logic [3:0] r3_0_q, r3_0_d;
  logic strap_q, strap_d;
  logic swrst_q, swrst_d;
  logic [31:0] rdat_q, rdat_d;
  logic [REG_W-1:0] c2_view;
  logic [REG_W-1:0] im_view;

  mic_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .ack_o(ack_o),
    .wr_o(wr),
    .rd_o(rd)
  );

  // Field positions are fixed, so only a 16-bit register serves
  if (REG_W != 16) begin : g_width_check
    $error("mic_regs: REG_W must be 16");
  end

  assign wdat = dat_i[REG_W-1:0];
  assign lanes = sel_i[1:0];

  always_comb begin
    c2_view = '0;
    c2_view[mic_pkg::C2_LOOP_BIT] = loop_q;
    c2_view[mic_pkg::C2_SPD_LSB_BIT] = spd_pend_q[0];
    c2_view[mic_pkg::C2_SPD_LSB_BIT-1:mic_pkg::C2_SPD_MSB_BIT+1] =
      mic_pkg::C2_RSV_12_7;
    c2_view[mic_pkg::C2_SPD_MSB_BIT] = spd_pend_q[1];
    c2_view[mic_pkg::C2_RXT_BIT] = rxt_pend_q;
    c2_view[mic_pkg::C2_TXT_BIT] = txt_pend_q;
    c2_view[mic_pkg::C2_BCE_BIT] = bce_q;
    c2_view[mic_pkg::C2_BCE_BIT-1:0] = mic_pkg::C2_RSV_2_0;
    im_view = '0;
    im_view[mic_pkg::IM_B15_BIT] = b15_q;
    im_view[mic_pkg::IM_SUPPLY_BIT] = sup_q;
    im_view[mic_pkg::IM_LOW_IO_BIT] = low_io_supply_i;
    im_view[mic_pkg::IM_LOW_IO_BIT-1:mic_pkg::IM_B7_BIT+1] = r11_8_q;
    im_view[mic_pkg::IM_B7_BIT] = b7_q;
    im_view[mic_pkg::IM_B6_BIT] = b6_q;
    im_view[IM_LOW_NIB_W-1:0] = r3_0_q;
  end

  always_comb begin
    loop_d = loop_q;
    spd_pend_d = spd_pend_q;
    spd_act_d = spd_act_q;
    rxt_pend_d = rxt_pend_q;
    rxt_act_d = rxt_act_q;
    txt_pend_d = txt_pend_q;
    txt_act_d = txt_act_q;
    bce_d = bce_q;
    sup_d = sup_q;
    b15_d = 1'b0;
    b7_d = b7_q;
    b6_d = b6_q;
    r11_8_d = r11_8_q;
    r3_0_d = r3_0_q;
    strap_d = 1'b0;
    swrst_d = 1'b0;
    rdat_d = rdat_q;
    // Strap sampled once, first cycle out of reset
    if (strap_q) begin
      sup_d = ^config_i;
    end
    // Soft reset pulse applies pending timing, clears loopback
    if (swrst_q) begin
      loop_d = 1'b0;
      spd_act_d = spd_pend_q;
      rxt_act_d = rxt_pend_q;
      txt_act_d = txt_pend_q;
    end
    if (wr && adr_i == mic_pkg::ADDR_CTRL2) begin
      if (lanes[1]) begin
        loop_d = wdat[mic_pkg::C2_LOOP_BIT];
        spd_pend_d[0] = wdat[mic_pkg::C2_SPD_LSB_BIT];
      end
      if (lanes[0]) begin
        spd_pend_d[1] = wdat[mic_pkg::C2_SPD_MSB_BIT];
        rxt_pend_d = wdat[mic_pkg::C2_RXT_BIT];
        txt_pend_d = wdat[mic_pkg::C2_TXT_BIT];
        bce_d = wdat[mic_pkg::C2_BCE_BIT];
      end
    end
    if (wr && adr_i == mic_pkg::ADDR_IMP) begin
      if (lanes[1]) begin
        b15_d = wdat[mic_pkg::IM_B15_BIT];
        sup_d = wdat[mic_pkg::IM_SUPPLY_BIT];
        r11_8_d = wdat[mic_pkg::IM_LOW_IO_BIT-1:mic_pkg::IM_B7_BIT+1];
      end
      if (lanes[0]) begin
        b7_d = wdat[mic_pkg::IM_B7_BIT];
        b6_d = wdat[mic_pkg::IM_B6_BIT];
        r3_0_d = wdat[IM_LOW_NIB_W-1:0];
      end
    end
    if (wr && adr_i == mic_pkg::ADDR_SWRST && lanes[1]) begin
      swrst_d = wdat[mic_pkg::SWRST_BIT];
    end
    if (rd) begin
      rdat_d = '0;
      if (adr_i == mic_pkg::ADDR_CTRL2) begin
        rdat_d[REG_W-1:0] = c2_view;
      end else if (adr_i == mic_pkg::ADDR_IMP) begin
        rdat_d[REG_W-1:0] = im_view;
      end
    end
  end

  // Hardware reset restores all; soft reset keeps retained bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_q <= 1'b0;
      spd_pend_q <= mic_pkg::SPEED_RST;
      spd_act_q <= mic_pkg::SPEED_RST;
      rxt_pend_q <= mic_pkg::RXT_RST;
      rxt_act_q <= mic_pkg::RXT_RST;
      txt_pend_q <= mic_pkg::TXT_RST;
      txt_act_q <= mic_pkg::TXT_RST;
      bce_q <= 1'b0;
      sup_q <= 1'b0;
      b15_q <= 1'b0;
      b7_q <= 1'b0;
      b6_q <= 1'b0;
      r11_8_q <= mic_pkg::IM_RSV_11_8_RST;
      r3_0_q <= mic_pkg::IM_RSV_3_0_RST;
      strap_q <= 1'b1;
      swrst_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      loop_q <= loop_d;
      spd_pend_q <= spd_pend_d;
      spd_act_q <= spd_act_d;
      rxt_pend_q <= rxt_pend_d;
      rxt_act_q <= rxt_act_d;
      txt_pend_q <= txt_pend_d;
      txt_act_q <= txt_act_d;
      bce_q <= bce_d;
      sup_q <= sup_d;
      b15_q <= b15_d;
      b7_q <= b7_d;
      b6_q <= b6_d;
      r11_8_q <= r11_8_d;
      r3_0_q <= r3_0_d;
      strap_q <= strap_d;
      swrst_q <= swrst_d;
      rdat_q <= rdat_d;
    end
  end

  assign dat_o = rdat_q;
  assign soft_reset_o = swrst_q;
  assign ctrl_o.line_loopback = loop_q;
  assign ctrl_o.speed = spd_act_q;
  assign ctrl_o.rx_clk_centered = rxt_act_q;
  assign ctrl_o.tx_clk_delay = txt_act_q;
  assign ctrl_o.block_carrier_ext = bce_q;
  assign ctrl_o.io_supply_level = sup_q;
  // Default speed when link down or in MAC loopback
  assign mac_speed_o = (!link_up_i || mac_loopback_i) ? spd_act_q
                       : link_speed_i;
endmodule

// file: hdl/mic_pkg.sv
// Package: register map, field positions and types of the MAC interface control block
package mic_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [4:0] REG_CTRL2_IDX = 5'h15;
  localparam logic [4:0] REG_IMP_IDX = 5'h18;
  localparam logic [4:0] REG_SWRST_IDX = 5'h1f;
  localparam int IDX_TO_BYTE_SHIFT = 2;
  localparam logic [6:0] ADDR_CTRL2 = {REG_CTRL2_IDX, 2'b00};
  localparam logic [6:0] ADDR_IMP = {REG_IMP_IDX, 2'b00};
  localparam logic [6:0] ADDR_SWRST = {REG_SWRST_IDX, 2'b00};

  // Control register two fields
  localparam int C2_LOOP_BIT = 14;
  localparam int C2_SPD_LSB_BIT = 13;
  localparam int C2_SPD_MSB_BIT = 6;
  localparam int C2_RXT_BIT = 5;
  localparam int C2_TXT_BIT = 4;
  localparam int C2_BCE_BIT = 3;
  localparam logic [5:0] C2_RSV_12_7 = 6'h20;
  localparam logic [2:0] C2_RSV_2_0 = 3'h6;
  localparam logic [1:0] SPEED_RST = 2'h2;
  localparam logic RXT_RST = 1'h1;
  localparam logic TXT_RST = 1'h1;

  // Impedance override fields
  localparam int IM_B15_BIT = 15;
  localparam int IM_SUPPLY_BIT = 13;
  localparam int IM_LOW_IO_BIT = 12;
  localparam int IM_B7_BIT = 7;
  localparam int IM_B6_BIT = 6;
  localparam logic [3:0] IM_RSV_11_8_RST = 4'h8;
  localparam logic [3:0] IM_RSV_3_0_RST = 4'h8;

  // Software reset register: writing this bit requests a soft reset
  localparam int SWRST_BIT = 15;

  typedef enum logic [1:0] {
    MIC_SPD_10 = 2'h0,
    MIC_SPD_100 = 2'h1,
    MIC_SPD_1000 = 2'h2
  } mic_speed_t;

  // Settings that act on the datapath
  typedef struct packed {
    logic line_loopback;
    logic [1:0] speed;
    logic rx_clk_centered;
    logic tx_clk_delay;
    logic block_carrier_ext;
    logic io_supply_level;
  } mic_ctrl_t;
endpackage

// file: hdl/mic_wb_slave.sv
// Wishbone classic slave handshake with one-cycle ack
`timescale 1ns/100ps
module mic_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  output logic ack_o,
  output logic wr_o,
  output logic rd_o
);
  logic ack_q;
  logic ack_d;

  always_comb begin
    ack_d = cyc_i && stb_i && !ack_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign ack_o = ack_q;
  assign wr_o = ack_q && cyc_i && stb_i && we_i;
  assign rd_o = ack_d && !we_i;
endmodule

// file: testbench/mic_regs_sva.sv
// Checker: port-level properties of the control register block
`timescale 1ns/100ps
module mic_regs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] adr_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [1:0] config_i,
  input wire logic low_io_supply_i,
  input wire logic link_up_i,
  input wire logic mac_loopback_i,
  input wire logic [1:0] link_speed_i,
  input wire mic_pkg::mic_ctrl_t ctrl_o,
  input wire logic [1:0] mac_speed_o,
  input wire logic soft_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_loop_soft_clear:
    assert property (soft_reset_o |=> !ctrl_o.line_loopback)
    else $error("loopback kept over soft reset");
  a_speed_link_down:
    assert property (!link_up_i |-> mac_speed_o == ctrl_o.speed)
    else $error("link down speed wrong");
  a_speed_link_up:
    assert property (link_up_i && !mac_loopback_i
      |-> mac_speed_o == link_speed_i)
    else $error("link up speed wrong");
  a_speed_mac_loop:
    assert property (mac_loopback_i |-> mac_speed_o == ctrl_o.speed)
    else $error("mac loopback speed wrong");
  a_timing_hold:
    assert property (!soft_reset_o |=> $stable(ctrl_o.speed)
      && $stable(ctrl_o.rx_clk_centered) && $stable(ctrl_o.tx_clk_delay))
    else $error("timing changed without soft reset");
  a_retain_soft:
    assert property (soft_reset_o |=> $stable(ctrl_o.block_carrier_ext)
      && $stable(ctrl_o.io_supply_level))
    else $error("retained bit lost");
  a_reset_values:
    assert property ($fell(rst_i) |-> ctrl_o.rx_clk_centered
      && ctrl_o.tx_clk_delay && !ctrl_o.block_carrier_ext
      && !ctrl_o.line_loopback)
    else $error("reset values wrong");
  a_supply_strap:
    assert property ($fell(rst_i)
      |=> ctrl_o.io_supply_level == ^$past(config_i))
    else $error("supply strap wrong");
  a_low_io_read:
    assert property (ack_o && !we_i && adr_i == mic_pkg::ADDR_IMP
      |-> dat_o[12] == low_io_supply_i)
    else $error("low io status wrong");
  cover property (soft_reset_o);
  cover property (mac_loopback_i && link_up_i);
  cover property (ack_o && we_i && adr_i == mic_pkg::ADDR_IMP);
  cover property ($fell(rst_i) && config_i == 2'h3);
endmodule
bind mic_regs mic_regs_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i),
  .ack_o(ack_o), .dat_o(dat_o), .config_i(config_i),
  .low_io_supply_i(low_io_supply_i), .link_up_i(link_up_i),
  .mac_loopback_i(mac_loopback_i), .link_speed_i(link_speed_i),
  .ctrl_o(ctrl_o), .mac_speed_o(mac_speed_o),
  .soft_reset_o(soft_reset_o)
);

// file: testbench/mic_mac_model.sv
// Far-side model: MAC link state and strap levels
`timescale 1ns/100ps
module mic_mac_model (
  input wire logic clk_i,
  input wire logic [1:0] mac_speed_i,
  output logic [1:0] config_o,
  output logic low_io_supply_o,
  output logic link_up_o,
  output logic mac_loopback_o,
  output logic [1:0] link_speed_o
);
  initial begin
    config_o = 2'h1;
    low_io_supply_o = 1'h1;
    link_up_o = 1'h0;
    mac_loopback_o = 1'h0;
    link_speed_o = 2'h0;
  end
  // Link changes just after an edge
  task automatic set_link(input logic up, lb, input logic [1:0] spd);
    @(posedge clk_i);
    link_up_o <= up;
    mac_loopback_o <= lb;
    link_speed_o <= spd;
  endtask
  // Strap and supply levels change ahead of a hardware reset
  task automatic set_config(input logic [1:0] cfg, input logic low);
    @(posedge clk_i);
    config_o <= cfg;
    low_io_supply_o <= low;
  endtask
endmodule

// file: testbench/mic_regs_bench.sv
// Bench: register access, resets and MAC speed selection
`timescale 1ns/100ps
module mic_regs_bench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [6:0] adr_i = 7'h00;
  logic [31:0] dat_i = 32'h0;
  logic we_i = 1'h0;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_o;
  logic ack_o, link_up_i, mac_loopback_i, low_io_supply_i, soft_reset_o;
  logic [1:0] config_i, link_speed_i, mac_speed_o;
  mic_pkg::mic_ctrl_t ctrl_o;
  logic [15:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  always #25 clk_i = ~clk_i;
  mic_regs uut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .config_i(config_i),
    .low_io_supply_i(low_io_supply_i), .link_up_i(link_up_i),
    .mac_loopback_i(mac_loopback_i), .link_speed_i(link_speed_i),
    .ctrl_o(ctrl_o), .mac_speed_o(mac_speed_o),
    .soft_reset_o(soft_reset_o));
  mic_mac_model mac (.clk_i(clk_i), .mac_speed_i(mac_speed_o),
    .config_o(config_i), .low_io_supply_o(low_io_supply_i),
    .link_up_o(link_up_i), .mac_loopback_o(mac_loopback_i),
    .link_speed_o(link_speed_i));
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [6:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {16'h0000, d};
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    rd = dat_o[15:0];
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic hw_reset;
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    hw_reset();
    wb(mic_pkg::ADDR_CTRL2, 1'h0, 16'h0);
    chk("ctrl two", 16'h1076, rd);
    chk("ctrl out", 16'h002d, {9'h000, ctrl_o});
    wb(mic_pkg::ADDR_IMP, 1'h0, 16'h0);
    chk("override", 16'h3808, rd);
    wb(mic_pkg::ADDR_CTRL2, 1'h0, 16'h0);
    wb(mic_pkg::ADDR_CTRL2, 1'h1, (rd & 16'h9f87) | 16'h6008);
    chk("ctrl out", 16'h006f, {9'h000, ctrl_o});
    wb(mic_pkg::ADDR_CTRL2, 1'h0, 16'h0);
    chk("ctrl two", 16'h700e, rd);
    chk("mac speed", 16'h0002, {14'h0, mac_speed_o});
    wb(mic_pkg::ADDR_SWRST, 1'h1, 16'h8000);
    chk("soft reset", 16'h0001, {15'h0, soft_reset_o});
    repeat (3) @(posedge clk_i);
    chk("ctrl out", 16'h0013, {9'h000, ctrl_o});
    chk("mac speed", 16'h0001, {14'h0, mac_speed_o});
    mac.set_link(1'h1, 1'h0, 2'h0);
    repeat (2) @(posedge clk_i);
    chk("mac speed", 16'h0000, {14'h0, mac_speed_o});
    mac.set_link(1'h1, 1'h1, 2'h0);
    repeat (2) @(posedge clk_i);
    chk("mac speed", 16'h0001, {14'h0, mac_speed_o});
    wb(mic_pkg::ADDR_IMP, 1'h0, 16'h0);
    wb(mic_pkg::ADDR_IMP, 1'h1, rd & 16'hdfff);
    wb(mic_pkg::ADDR_IMP, 1'h0, 16'h0);
    chk("override", 16'h1808, rd);
    wb(7'h40, 1'h1, 16'hffff);
    wb(7'h40, 1'h0, 16'h0);
    chk("unmapped", 16'h0000, rd);
    mac.set_config(2'h3, 1'h0);
    hw_reset();
    chk("ctrl out", 16'h002c, {9'h000, ctrl_o});
    wb(mic_pkg::ADDR_IMP, 1'h0, 16'h0);
    chk("override", 16'h0808, rd);
    end_sim();
  end
  initial begin
    #(50 * 4000);
    num_errors++;
    end_sim();
  end
endmodule
